// file: logic/hmc_top.sv
// Measurement scheduling and override control of the energy harvester.
// Functional notes
// - Five-bit regulation fraction, 42.5 to 89 percent.
// - Force bit 7 starts open-circuit measure unless skipped.
// - Force bit 6 starts thermal check if enabled.
// - Measurement time codes: 50, 100, 250, 500 ms.
// - Fixed settling equals base time when adaptive off.
// - Adaptive settling from pulse count, quarter to double.
// - Adaptive period stores count after twice base time.
// - Count ratio outside half to double forces measure unless asleep.
// - Period 64, 128, 256 base times; code 11 off.
// - Period off means no automatic measurements.
// - Three-bit peak current code drives the converter.
// - Thermal disabled never affects boost operation.
// - Thermal checks each period or forced; may stop boost.
// - Wake override holds wake output high.
// - Device disable bit overrides the enable pin.
// - Boost disable bit overrides internal boost control.
// - Periodic open-circuit bit selects automatic open-circuit runs.
// - Periodic thermal needs its bit and thermal enable.
`timescale 1ns/1ns
`default_nettype none
`include "hmc_defs.svh"
module hmc_top #(
    parameter int unsigned TICK_CYCLES = `HMC_TICK_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire hmc_pkg::hmc_reg_req_t reg_req_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [15:0] harvest_pulse_count_i,
    input wire logic skip_open_circuit_flag_i,
    input wire logic sleep_i,
    input wire logic periodic_open_circuit_en_i,
    input wire logic periodic_thermal_en_i,
    input wire logic boost_logic_en_i,
    input wire logic wake_cmp_i,
    input wire logic enable_pin_n_i,
    input wire logic thermal_trip_i,
    output logic [4:0] frac_setpoint_o,
    output logic [2:0] boost_peak_current_sel_o,
    output logic ocv_settle_o,
    output logic ocv_sample_o,
    output logic thermal_check_o,
    output logic wake_o,
    output logic device_en_o,
    output logic boost_en_o
);
    logic [4:0] frac;
    hmc_pkg::hmc_meas_cfg_t meas;
    hmc_pkg::hmc_dev_cntl_t dev;
    hmc_pkg::hmc_ocv_state_t state;
    logic tick;
    logic [1:0] wake_sync;
    logic [1:0] enb_sync;
    logic [1:0] trip_sync;
    logic ocv_req;
    logic thermal_hot;
    logic [11:0] settle_cnt;
    logic [11:0] settle_target;
    logic [19:0] period_cnt;
    logic [11:0] store_cnt;
    logic store_wait;
    logic stored_valid;
    logic [15:0] stored_count;

    // Pin inputs cross in through two flops before any logic sees them.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wake_sync <= 2'h0;
            enb_sync <= 2'h3;
            trip_sync <= 2'h0;
        end else begin
            wake_sync <= {wake_sync[0], wake_cmp_i};
            enb_sync <= {enb_sync[0], enable_pin_n_i};
            trip_sync <= {trip_sync[0], thermal_trip_i};
        end
    end

    hmc_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .tick_o(tick)
    );

    // Register decode.
    wire wr_frac = reg_req_i.wr && (reg_req_i.addr == `HMC_OFS_FRAC);
    wire wr_meas = reg_req_i.wr && (reg_req_i.addr == `HMC_OFS_MEAS);
    wire wr_dev = reg_req_i.wr && (reg_req_i.addr == `HMC_OFS_DEV);
    wire force_ocv_wr = wr_meas && reg_req_i.wdata[`HMC_BIT_FORCE_OCV];
    wire force_thm_wr = wr_meas && reg_req_i.wdata[`HMC_BIT_FORCE_THM];
    wire [7:0] rd_value;
    // Force bits are never stored, so they read back as zero.
    assign rd_value = (reg_req_i.addr == `HMC_OFS_FRAC) ? {3'h0, frac} :
                      (reg_req_i.addr == `HMC_OFS_MEAS) ? {2'h0, meas[5:0]} :
                      (reg_req_i.addr == `HMC_OFS_DEV) ? {1'b0, dev[6:0]} :
                      8'h00;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            frac <= 5'(`HMC_RST_FRAC);
            meas <= `HMC_RST_MEAS;
            dev <= `HMC_RST_DEV;
        end else begin
            if (wr_frac) frac <= reg_req_i.wdata[4:0];
            if (wr_meas) meas <= {2'h0, reg_req_i.wdata[5:0]};
            if (wr_dev) dev <= {1'b0, reg_req_i.wdata[6:0]};
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) reg_rdata_o <= 8'h00;
        else if (reg_req_i.rd) reg_rdata_o <= rd_value;
    end

    // Base time in quarter-millisecond ticks, and the period derived from it.
    wire [11:0] base_ticks = (meas.tmeas == 2'h0) ? 12'(`HMC_TMEAS0_MS * `HMC_TICKS_PER_MS) :
                             (meas.tmeas == 2'h1) ? 12'(`HMC_TMEAS1_MS * `HMC_TICKS_PER_MS) :
                             (meas.tmeas == 2'h2) ? 12'(`HMC_TMEAS2_MS * `HMC_TICKS_PER_MS) :
                             12'(`HMC_TMEAS3_MS * `HMC_TICKS_PER_MS);
    wire period_off = (meas.tper == `HMC_TPER_OFF);
    wire [19:0] period_ticks = (meas.tper == 2'h0) ? {2'h0, base_ticks, 6'h00} :
                               (meas.tper == 2'h1) ? {1'b0, base_ticks, 7'h00} :
                               {base_ticks, 8'h00};
    // Strong harvest settles fast; a weak source gets up to twice the base time.
    wire [11:0] adapt_settle = (harvest_pulse_count_i >= `HMC_HC_FAST) ? {2'h0, base_ticks[11:2]} :
                               (harvest_pulse_count_i >= `HMC_HC_MID) ? {1'b0, base_ticks[11:1]} :
                               (harvest_pulse_count_i >= `HMC_HC_SLOW) ? base_ticks :
                               {base_ticks[10:0], 1'b0};
    wire [11:0] next_settle_target = meas.adaptive_settling_sel ? adapt_settle
                                                                 : base_ticks;

    // Automatic period events never fire while the period is off.
    wire period_evt = tick && !period_off && (period_cnt >= period_ticks - 20'h00001);
    wire auto_ocv = period_evt && periodic_open_circuit_en_i;
    wire auto_thm = period_evt && periodic_thermal_en_i && dev.thermal_monitor_en;
    wire adapt_on = meas.adaptive_period_en && !period_off;
    wire ratio_low = {harvest_pulse_count_i, 1'b0} < {1'b0, stored_count};
    wire ratio_high = {1'b0, harvest_pulse_count_i} > {stored_count, 1'b0};
    wire adapt_trig = adapt_on && stored_valid && !sleep_i && (ratio_low || ratio_high);
    wire force_ocv_ok = force_ocv_wr && !skip_open_circuit_flag_i;
    wire ocv_start = (state == hmc_pkg::HMC_OCV_IDLE) && ocv_req;
    wire settle_end = tick && (settle_cnt >= settle_target - 12'h001);

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) period_cnt <= 20'h00000;
        else if (period_off || period_evt) period_cnt <= 20'h00000;
        else if (tick) period_cnt <= period_cnt + 20'h00001;
    end

    // A new request set in the same cycle as a start is kept, not lost.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) ocv_req <= 1'b0;
        else if (force_ocv_ok || auto_ocv || adapt_trig) ocv_req <= 1'b1;
        else if (ocv_start) ocv_req <= 1'b0;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= hmc_pkg::HMC_OCV_IDLE;
            settle_cnt <= 12'h000;
            settle_target <= 12'h001;
        end else begin
            case (state)
                hmc_pkg::HMC_OCV_IDLE: begin
                    settle_cnt <= 12'h000;
                    if (ocv_start) begin
                        settle_target <= next_settle_target;
                        state <= hmc_pkg::HMC_OCV_SETTLE;
                    end
                end
                hmc_pkg::HMC_OCV_SETTLE: begin
                    if (settle_end) state <= hmc_pkg::HMC_OCV_DONE;
                    else if (tick) settle_cnt <= settle_cnt + 12'h001;
                end
                default: state <= hmc_pkg::HMC_OCV_IDLE;
            endcase
        end
    end

    assign ocv_settle_o = (state == hmc_pkg::HMC_OCV_SETTLE);
    assign ocv_sample_o = (state == hmc_pkg::HMC_OCV_DONE);

    // After each measurement, wait twice the base time before the count is taken as reference.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            store_wait <= 1'b0;
            store_cnt <= 12'h000;
            stored_valid <= 1'b0;
            stored_count <= 16'h0000;
        end else if (!adapt_on || ocv_settle_o || adapt_trig) begin
            store_wait <= 1'b0;
            store_cnt <= 12'h000;
            stored_valid <= 1'b0;
        end else if (ocv_sample_o) begin
            store_wait <= 1'b1;
            store_cnt <= 12'h000;
            stored_valid <= 1'b0;
        end else if (store_wait && tick) begin
            if (store_cnt >= {base_ticks[10:0], 1'b0} - 12'h001) begin
                store_wait <= 1'b0;
                stored_valid <= 1'b1;
                stored_count <= harvest_pulse_count_i;
            end else begin
                store_cnt <= store_cnt + 12'h001;
            end
        end
    end

    // Thermal check pulse; the result is taken one cycle later from the synced comparator.
    wire thm_evt = (force_thm_wr && dev.thermal_monitor_en) || auto_thm;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            thermal_check_o <= 1'b0;
            thermal_hot <= 1'b0;
        end else begin
            thermal_check_o <= thm_evt;
            if (!dev.thermal_monitor_en) thermal_hot <= 1'b0;
            else if (thermal_check_o) thermal_hot <= trip_sync[1];
        end
    end

    assign frac_setpoint_o = frac;
    assign boost_peak_current_sel_o = dev.boost_peak_current_sel;
    assign wake_o = dev.wake_output_override || wake_sync[1];
    assign device_en_o = !enb_sync[1] && !dev.device_disable_bit;
    assign boost_en_o = device_en_o && boost_logic_en_i && !dev.boost_disable_bit
                        && !thermal_hot;

    sequence s_force_ocv;
        force_ocv_ok && state == hmc_pkg::HMC_OCV_IDLE && !ocv_req;
    endsequence
    property p_force_ocv;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        s_force_ocv |=> ocv_req ##1 ocv_settle_o;
    endproperty
    a_force_ocv: assert property (p_force_ocv) else $error("forced measure did not start");
    property p_force_thm;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        force_thm_wr |=> (thermal_check_o == $past(dev.thermal_monitor_en));
    endproperty
    a_force_thm: assert property (p_force_thm) else $error("thermal force mismatch");
    property p_settle_fixed;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (ocv_start && !meas.adaptive_settling_sel) |=> (settle_target == $past(base_ticks));
    endproperty
    a_settle_fixed: assert property (p_settle_fixed) else $error("fixed settle wrong");
    property p_period_off;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (period_off && !force_ocv_wr && !force_thm_wr) |=> !$rose(ocv_req) && !thermal_check_o;
    endproperty
    a_period_off: assert property (p_period_off) else $error("automatic run while off");
    property p_thm_off;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !dev.thermal_monitor_en ##1 !dev.thermal_monitor_en |-> !thermal_hot;
    endproperty
    a_thm_off: assert property (p_thm_off) else $error("thermal affects boost");
    property p_wake;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        dev.wake_output_override |-> wake_o;
    endproperty
    a_wake: assert property (p_wake) else $error("wake not forced");
    property p_dev_dis;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        dev.device_disable_bit |-> !device_en_o && !boost_en_o;
    endproperty
    a_dev_dis: assert property (p_dev_dis) else $error("device not disabled");
    property p_boost_dis;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        dev.boost_disable_bit |-> !boost_en_o;
    endproperty
    a_boost_dis: assert property (p_boost_dis) else $error("boost not disabled");
    property p_rd_force;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (reg_req_i.rd && reg_req_i.addr == `HMC_OFS_MEAS) |=> reg_rdata_o[7:6] == 2'h0;
    endproperty
    a_rd_force: assert property (p_rd_force) else $error("force bits read nonzero");
    property p_rd_unmapped;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (reg_req_i.rd && reg_req_i.addr != `HMC_OFS_FRAC && reg_req_i.addr != `HMC_OFS_MEAS
            && reg_req_i.addr != `HMC_OFS_DEV) |=> reg_rdata_o == 8'h00;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read nonzero");
    property p_settle_adapt;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (ocv_start && meas.adaptive_settling_sel) |=> (settle_target >= ($past(base_ticks) >> 2))
            && (settle_target <= ($past(base_ticks) << 1));
    endproperty
    a_settle_adapt: assert property (p_settle_adapt) else $error("settle out of range");
    sequence s_settle_end;
        ocv_settle_o && settle_end;
    endsequence
    property p_sample_pulse;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        s_settle_end |=> ocv_sample_o ##1 (!ocv_sample_o && !ocv_settle_o);
    endproperty
    a_sample_pulse: assert property (p_sample_pulse) else $error("sample pulse wrong");
    property p_thm_hot;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (thermal_check_o && dev.thermal_monitor_en) |=> (thermal_hot == $past(trip_sync[1]));
    endproperty
    a_thm_hot: assert property (p_thm_hot) else $error("thermal result not taken");
endmodule : hmc_top
`default_nettype wire

// file: logic/hmc_defs.svh
// Register offsets, field positions, reset values and timing counts of the measure control block.
`ifndef HMC_DEFS_SVH
`define HMC_DEFS_SVH

`define HMC_OFS_FRAC 8'h06
`define HMC_OFS_MEAS 8'h07
`define HMC_OFS_DEV 8'h08

`define HMC_RST_FRAC 8'h19
`define HMC_RST_MEAS 8'h0e
`define HMC_RST_DEV 8'h30

`define HMC_BIT_FORCE_OCV 7
`define HMC_BIT_FORCE_THM 6
`define HMC_TPER_OFF 2'h3

`define HMC_CLK_PS 4000
`define HMC_TICK_PS 250000000
`define HMC_TICK_CYCLES (`HMC_TICK_PS / `HMC_CLK_PS)

`define HMC_TMEAS0_MS 50
`define HMC_TMEAS1_MS 100
`define HMC_TMEAS2_MS 250
`define HMC_TMEAS3_MS 500
`define HMC_TICKS_PER_MS 4

`define HMC_HC_FAST 16'h1000
`define HMC_HC_MID 16'h0100
`define HMC_HC_SLOW 16'h0010

`endif

// file: logic/hmc_pkg.sv
// Types shared by the harvester measure control block.
`default_nettype none
package hmc_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hmc_reg_req_t;

    typedef struct packed {
        logic force_open_circuit_measure;
        logic force_thermal_check;
        logic [1:0] tmeas;
        logic adaptive_settling_sel;
        logic adaptive_period_en;
        logic [1:0] tper;
    } hmc_meas_cfg_t;

    typedef struct packed {
        logic reserved;
        logic [2:0] boost_peak_current_sel;
        logic thermal_monitor_en;
        logic wake_output_override;
        logic device_disable_bit;
        logic boost_disable_bit;
    } hmc_dev_cntl_t;

    typedef enum logic [1:0] {
        HMC_OCV_IDLE = 2'b00,
        HMC_OCV_SETTLE = 2'b01,
        HMC_OCV_DONE = 2'b11
    } hmc_ocv_state_t;

endpackage : hmc_pkg
`default_nettype wire

// file: logic/hmc_tick.sv
// Divider that turns the reference clock into a quarter-millisecond enable pulse.
`timescale 1ns/1ns
`default_nettype none
module hmc_tick #(
    parameter int unsigned TICK_CYCLES = 62500
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    output logic tick_o
);
    logic [31:0] count;
    wire last = (count == TICK_CYCLES - 1);

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count <= 32'h0000_0000;
            tick_o <= 1'b0;
        end else begin
            count <= last ? 32'h0000_0000 : count + 32'h0000_0001;
            tick_o <= last;
        end
    end
endmodule : hmc_tick
`default_nettype wire

// file: sim/hmc_host.sv
// Host model that issues single-byte register accesses to the measure control block.
`timescale 1ns/1ns
`default_nettype none
module hmc_host (
    input wire logic ref_clk_i,
    input wire logic [7:0] reg_rdata_i,
    output var hmc_pkg::hmc_reg_req_t reg_req_o
);
    initial reg_req_o = '0;

    // Requests change at the falling edge and stand for exactly one rising edge.
    // The idle bus shows inverted address and data so that stale values cannot pass.
    // Only the three mapped registers and one unmapped address are ever used.
    task automatic xfer(input logic rd, input logic [7:0] addr, input logic [7:0] wd,
                        output logic [7:0] rdata);
        @(negedge ref_clk_i);
        reg_req_o = '{wr: !rd, rd: rd, addr: addr, wdata: wd};
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        rdata = reg_rdata_i;
        reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wd};
    endtask : xfer
endmodule : hmc_host
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the harvester measure control block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam int TK = 4;
    localparam int TPM = 4;
    logic ref_clk, resetn, skip, slp, poc, pth, ble, wk, enn, trip;
    logic [15:0] hc;
    logic [7:0] rdata, rd;
    logic [4:0] frac;
    logic [2:0] pk;
    logic settle, sample, tchk, wake, dev_en, bst_en, f_ocv, f_thm;
    hmc_pkg::hmc_reg_req_t req;
    int err_total, n_tests, n, i;
    int ms[4] = '{50, 100, 250, 500};
    logic [15:0] hc_tbl[4] = '{16'h1000, 16'h0100, 16'h0010, 16'h0001};
    logic [31:0] seed;

    hmc_top #(.TICK_CYCLES(TK)) i_hmc_top (
        .ref_clk_i(ref_clk), .resetn_i(resetn), .reg_req_i(req), .reg_rdata_o(rdata),
        .harvest_pulse_count_i(hc), .skip_open_circuit_flag_i(skip), .sleep_i(slp),
        .periodic_open_circuit_en_i(poc), .periodic_thermal_en_i(pth),
        .boost_logic_en_i(ble), .wake_cmp_i(wk), .enable_pin_n_i(enn),
        .thermal_trip_i(trip), .frac_setpoint_o(frac), .boost_peak_current_sel_o(pk),
        .ocv_settle_o(settle), .ocv_sample_o(sample), .thermal_check_o(tchk),
        .wake_o(wake), .device_en_o(dev_en), .boost_en_o(bst_en)
    );
    hmc_host i_hmc_host (.ref_clk_i(ref_clk), .reg_rdata_i(rdata), .reg_req_o(req));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    endfunction : lfsr

    // Tick phase is unknown, so a settle length is accepted within one tick either way.
    function automatic logic ok(input int c, input int t);
        return (c > (t - 1) * TK) && (c <= (t + 1) * TK);
    endfunction : ok

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] x;
        i_hmc_host.xfer(1'b0, a, d, x);
    endtask : wr

    task automatic meas(output int c);
        int k;
        c = 0;
        for (k = 0; k < 20 && settle !== 1'b1; k++) @(negedge ref_clk);
        while (settle === 1'b1 && c < 20000) begin
            c++;
            @(negedge ref_clk);
        end
        chk(sample, 1'b1);
        @(negedge ref_clk);
        chk(sample, 1'b0);
    endtask : meas

    task automatic final_report;
        $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (90000) @(posedge ref_clk);
        err_total++;
        final_report();
    end

    initial begin
        {resetn, skip, slp, poc, pth, wk, enn, trip} = '0;
        ble = 1'b1;
        hc = 16'h0;
        seed = 32'hb9adf851;
        repeat (20) @(negedge ref_clk);
        resetn = 1'b1;
        i_hmc_host.xfer(1'b1, 8'h06, 8'h00, rd);
        chk(rd, 8'h19);
        i_hmc_host.xfer(1'b1, 8'h07, 8'h00, rd);
        chk(rd, 8'h0e);
        i_hmc_host.xfer(1'b1, 8'h08, 8'h00, rd);
        chk(rd, 8'h30);
        i_hmc_host.xfer(1'b1, 8'h05, 8'h00, rd);
        chk(rd, 8'h00);
        wr(8'h07, 8'h03);
        for (i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            wr(8'h06, seed[7:0]);
            wr(8'h08, seed[15:8]);
            {wk, enn, ble} = seed[18:16];
            repeat (3) @(negedge ref_clk);
            chk(frac, seed[4:0]);
            chk(pk, seed[14:12]);
            chk(wake, wk | seed[10]);
            chk(dev_en, !enn & !seed[9]);
            chk(bst_en, !enn & !seed[9] & ble & !seed[8]);
            i_hmc_host.xfer(1'b1, 8'h08, 8'h00, rd);
            chk(rd, {1'b0, seed[14:8]});
        end
        {wk, enn, ble} = 3'b001;
        wr(8'h08, 8'h30);
        for (i = 0; i < 4; i++) begin
            // With the automatic period off the host forces each run itself.
            wr(8'h07, {2'b10, i[1:0], 4'h3});
            meas(n);
            chk(ok(n, ms[i] * TPM), 1'b1);
            i_hmc_host.xfer(1'b1, 8'h07, 8'h00, rd);
            chk(rd, {2'b00, i[1:0], 4'h3});
        end
        {skip, poc, pth} = 3'b111;
        wr(8'h07, 8'h83);
        n = 0;
        repeat (100) begin
            @(negedge ref_clk);
            n += settle;
        end
        chk(n, 0);
        {skip, poc, pth} = 3'b000;
        for (i = 0; i < 4; i++) begin
            hc = hc_tbl[i];
            wr(8'h07, 8'h8b);
            meas(n);
            chk(ok(n, (ms[0] * TPM / 4) << i), 1'b1);
        end
        trip = 1'b1;
        wr(8'h07, 8'h43);
        n = 0;
        repeat (20) begin
            n += tchk;
            @(negedge ref_clk);
        end
        chk(n, 0);
        chk(bst_en, 1'b1);
        wr(8'h08, 8'h38);
        wr(8'h07, 8'h43);
        chk(tchk, 1'b1);
        @(negedge ref_clk);
        chk(tchk, 1'b0);
        chk(bst_en, 1'b0);
        wr(8'h08, 8'h30);
        @(negedge ref_clk);
        chk(bst_en, 1'b1);
        trip = 1'b0;
        wr(8'h08, 8'h38);
        {poc, pth} = 2'b11;
        {f_ocv, f_thm} = 2'b00;
        // Period code 00 at base code 00 is 64 base times; allow a little slack.
        wr(8'h07, 8'h00);
        for (i = 0; i < 64 * ms[0] * TPM * TK + 2000 && !(f_ocv && f_thm); i++) begin
            @(negedge ref_clk);
            f_ocv |= settle;
            f_thm |= tchk;
        end
        chk(f_ocv, 1'b1);
        chk(f_thm, 1'b1);
        n = 64 * ms[0] * TPM * TK;
        chk((i > n - TK) && (i <= n + TK), 1'b1);
        meas(n);
        chk(ok(n, ms[0] * TPM), 1'b1);
        // Adaptive period: the reference is only taken after twice the base time.
        {poc, pth} = 2'b00;
        hc = 16'h1000;
        wr(8'h07, 8'h84);
        meas(n);
        chk(ok(n, ms[0] * TPM), 1'b1);
        n = 0;
        hc = 16'h0100;
        repeat (2 * ms[0] * TPM * TK - 100) begin
            n += settle;
            @(negedge ref_clk);
        end
        hc = 16'h1000;
        repeat (120) begin
            n += settle;
            @(negedge ref_clk);
        end
        chk(n, 0);
        {slp, hc} = {1'b1, 16'h0100};
        repeat (20) begin
            n += settle;
            @(negedge ref_clk);
        end
        chk(n, 0);
        slp = 1'b0;
        meas(n);
        chk(ok(n, ms[0] * TPM), 1'b1);
        final_report();
    end
endmodule : tb_top
`default_nettype wire
